// ===== dcp_pkg.sv
package dcp_pkg;

   // ----------------------------------------------------------------------
   // Host port geometry
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int REG_COUNT = 40;
   localparam int SERIAL_FRAME_BITS = 16;
   localparam logic [4:0] SERIAL_ADDR_DONE = 5'h07;
   localparam logic [4:0] SERIAL_LAST_BIT = 5'h0f;
   localparam logic [4:0] SERIAL_END = 5'h10;

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [5:0] UPDATE_CLK_ADDR_3 = 6'h16;
   localparam logic [5:0] UPDATE_CLK_ADDR_2 = 6'h17;
   localparam logic [5:0] UPDATE_CLK_ADDR_1 = 6'h18;
   localparam logic [5:0] UPDATE_CLK_ADDR_0 = 6'h19;
   localparam logic [5:0] POWER_DOWN_ADDR = 6'h1d;
   localparam logic [5:0] CLK_MULT_ADDR = 6'h1e;
   localparam logic [5:0] UPDATE_MODE_ADDR = 6'h1f;
   localparam logic [5:0] BYPASS_ADDR = 6'h20;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int PWR_DIGITAL_BIT = 0;
   localparam int PWR_DAC_BIT = 1;
   localparam int PWR_CTRL_DAC_BIT = 2;
   localparam int PWR_COMPARATOR_BIT = 4;
   localparam int MULT_MSB = 4;
   localparam int MULT_LSB = 0;
   localparam int PLL_BYPASS_BIT = 5;
   localparam int PLL_RANGE_BIT = 6;
   localparam int INT_UPDATE_BIT = 0;
   localparam int QUAD_SOURCE_BIT = 4;
   localparam int AMP_BYPASS_BIT = 5;
   localparam int INV_SINC_BYPASS_BIT = 6;
   localparam int READ_FLAG_BIT = 15;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] BUFFER_RESET = 8'h00;
   localparam logic [7:0] CLK_MULT_RESET = 8'h24;

   // ----------------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------------
   localparam int MASTER_RESET_CYCLES = 10;
   localparam int SERIAL_HALF_CYCLES = 2;
   localparam int UPDATE_STROBE_CYCLES = 2;

   typedef enum {HOST_IDLE, HOST_PAR_WAIT, HOST_SERIAL, HOST_RESET} dcp_host_state_type;

   function automatic logic [7:0] regDefault(input int index);
      regDefault = (index == int'(CLK_MULT_ADDR)) ? CLK_MULT_RESET : BUFFER_RESET;
   endfunction : regDefault

endpackage : dcp_pkg

// ===== dcp_link_if.sv
`timescale 1ns/1ps
interface dcp_link_if;
   import dcp_pkg::*;
   logic parallelSelect;
   logic [ADDR_W-1:0] address;
   logic [DATA_W-1:0] writeData;
   logic [DATA_W-1:0] readData;
   logic writeEn;
   logic readEn;
   logic serialClock;
   logic serialChipSelectN;
   logic serialDataIn;
   logic serialDataOut;
   logic registerTransferStrobe;
   logic masterReset;

   modport device (
      input parallelSelect, address, writeData, writeEn, readEn,
      input serialClock, serialChipSelectN, serialDataIn,
      input registerTransferStrobe, masterReset,
      output readData, serialDataOut
   );
   modport host (
      output parallelSelect, address, writeData, writeEn, readEn,
      output serialClock, serialChipSelectN, serialDataIn,
      output registerTransferStrobe, masterReset,
      input readData, serialDataOut
   );
endinterface : dcp_link_if

// ===== dcp_serial_slave.sv
`timescale 1ns/1ps
module dcp_serial_slave
   import dcp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clear,
   // Serial pins
   input wire logic serialClock,
   input wire logic serialChipSelectN,
   input wire logic serialDataIn,
   output logic serialDataOut,
   // Register access
   input wire logic [DATA_W-1:0] readByte,
   output logic [ADDR_W-1:0] address,
   output logic writePulse,
   output logic [DATA_W-1:0] writeData
);

   logic sclkPrev_q;
   logic [4:0] bitCount_q;
   logic [SERIAL_FRAME_BITS-1:0] shiftIn_q;
   logic [DATA_W-1:0] shiftOut_q;
   logic readMode_q;
   logic [ADDR_W-1:0] addr_q;
   logic writePulse_q;
   logic [DATA_W-1:0] writeData_q;

   wire logic rise = serialClock & ~sclkPrev_q & ~serialChipSelectN & (bitCount_q < SERIAL_END);
   wire logic [ADDR_W-1:0] instrAddr = {shiftIn_q[ADDR_W-2:0], serialDataIn};
   wire logic addrDone = (bitCount_q == SERIAL_ADDR_DONE);

   // The address is offered one cycle early so the read byte is ready to load.
   assign address = addrDone ? instrAddr : addr_q;
   assign serialDataOut = shiftOut_q[DATA_W-1] & readMode_q;
   assign writePulse = writePulse_q;
   assign writeData = writeData_q;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sclkPrev_q <= 1'b0;
         bitCount_q <= 5'h00;
         shiftIn_q <= '0;
         shiftOut_q <= '0;
         readMode_q <= 1'b0;
         addr_q <= '0;
         writePulse_q <= 1'b0;
         writeData_q <= '0;
      end
      else
      begin
         sclkPrev_q <= serialClock;
         writePulse_q <= 1'b0;
         if (clear || serialChipSelectN)
         begin
            bitCount_q <= 5'h00;
            readMode_q <= 1'b0;
         end
         else if (rise)
         begin
            shiftIn_q <= {shiftIn_q[SERIAL_FRAME_BITS-2:0], serialDataIn};
            bitCount_q <= bitCount_q + 5'h01;
            if (addrDone)
            begin
               readMode_q <= shiftIn_q[6];
               addr_q <= instrAddr;
               shiftOut_q <= readByte;
            end
            else
            begin
               shiftOut_q <= {shiftOut_q[DATA_W-2:0], 1'b0};
            end
            if (bitCount_q == SERIAL_LAST_BIT && !readMode_q)
            begin
               writePulse_q <= 1'b1;
               writeData_q <= {shiftIn_q[DATA_W-2:0], serialDataIn};
            end
         end
      end
   end

endmodule : dcp_serial_slave

// ===== dcp_device.sv
`timescale 1ns/1ps
// What this block does
// - Inverse sinc on by default, bypass bit disables.
// - Control-converter path skips inverse sinc.
// - Five-bit field at 1E sets multiplier.
// - Multiplier code is plain binary factor.
// - System clock from multiplier or reference directly.
// - PLL bypass bit at 1E disengages multiplier.
// - Software sets range bit above 200 MHz.
// - Differential select pin picks reference input type.
// - Each power-down bit at 1D powers stage down.
// - All four power-down bits give full power-down.
// - Bypass bits at 20 bypass sinc, amplitude multiplier.
// - Strap picks parallel or serial host port.
// - All registers writable and readable either mode.
// - Writes buffered, active only after transfer.
// - Transfer by internal timer or external strobe.
// - Port works without reference; transfer needs it.
// - Master reset held ten cycles loads defaults.
// - Internal update bit selects down-counter transfers.
// - Source bit feeds converter from host data.
module dcp_device
   import dcp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Host link
   dcp_link_if.device link,
   // Reference clock pins
   input wire logic differentialRefclockSelect,
   input wire logic referenceClockRunning,
   // Clock configuration
   output logic [MULT_MSB:MULT_LSB] multiplierFactor,
   output logic multiplierEngaged,
   output logic systemClockFromMultiplier,
   output logic pllHighRange,
   output logic referenceInputDifferential,
   // Power and bypass
   output logic [3:0] stagePowerDownBits,
   output logic fullPowerDown,
   output logic invSincActiveI,
   output logic invSincActiveQ,
   output logic ampMultiplierBypass,
   // Update and converter source
   output logic quadConverterSourceSelect,
   output logic internalUpdateMode,
   output logic transferPulse
);

   // ----------------------------------------------------------------------
   // Memories and registers
   // ----------------------------------------------------------------------
   logic [DATA_W-1:0] bufferMem [REG_COUNT];
   logic [DATA_W-1:0] activeBank [REG_COUNT];
   logic [DATA_W-1:0] readData_q;
   logic strobePrev_q;
   logic [1:0] refSync_q;
   logic [1:0] diffSync_q;
   logic halfRate_q;
   logic [31:0] updateCount_q;
   logic transferPulse_q;

   // ----------------------------------------------------------------------
   // Host port selection
   // ----------------------------------------------------------------------
   logic [ADDR_W-1:0] serialAddr;
   logic serialWrite;
   logic [DATA_W-1:0] serialWriteData;
   wire logic parWrite = link.parallelSelect & link.writeEn;
   wire logic parRead = link.parallelSelect & link.readEn;
   wire logic serWrite = ~link.parallelSelect & serialWrite;
   wire logic anyWrite = parWrite | serWrite;
   wire logic [ADDR_W-1:0] writeAddr = parWrite ? link.address : serialAddr;
   wire logic [DATA_W-1:0] writeByte = parWrite ? link.writeData : serialWriteData;
   wire logic writeMapped = anyWrite & (writeAddr < REG_COUNT);
   wire logic [DATA_W-1:0] serialReadByte =
      (serialAddr < REG_COUNT) ? bufferMem[serialAddr] : BUFFER_RESET;
   wire logic [DATA_W-1:0] parReadByte =
      (link.address < REG_COUNT) ? bufferMem[link.address] : BUFFER_RESET;

   dcp_serial_slave serialPort (
      .clk(clk),
      .resetn(resetn),
      .clear(link.masterReset),
      .serialClock(link.serialClock),
      .serialChipSelectN(link.serialChipSelectN | link.parallelSelect),
      .serialDataIn(link.serialDataIn),
      .serialDataOut(link.serialDataOut),
      .readByte(serialReadByte),
      .address(serialAddr),
      .writePulse(serialWrite),
      .writeData(serialWriteData)
   );

   assign link.readData = readData_q;

   // ----------------------------------------------------------------------
   // Transfer triggers
   // ----------------------------------------------------------------------
   wire logic refRunning = refSync_q[1];
   wire logic [31:0] updatePeriod = {activeBank[UPDATE_CLK_ADDR_3], activeBank[UPDATE_CLK_ADDR_2],
      activeBank[UPDATE_CLK_ADDR_1], activeBank[UPDATE_CLK_ADDR_0]};
   wire logic intMode = activeBank[UPDATE_MODE_ADDR][INT_UPDATE_BIT];
   wire logic strobeRise = link.registerTransferStrobe & ~strobePrev_q;
   // The down-counter steps on every second system clock, so transfers repeat
   // every (N + 1) * 2 cycles.
   wire logic intFire = intMode & halfRate_q & (updateCount_q == 32'h0);
   wire logic [31:0] updateCount_d = (updateCount_q == 32'h0) ? updatePeriod : updateCount_q - 32'h1;
   wire logic doTransfer = refRunning & (intMode ? intFire : strobeRise);

   // ----------------------------------------------------------------------
   // Buffer memory and active bank
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < REG_COUNT; i++)
         begin
            bufferMem[i] <= regDefault(i);
            activeBank[i] <= regDefault(i);
         end
      end
      else if (link.masterReset)
      begin
         for (int i = 0; i < REG_COUNT; i++)
         begin
            bufferMem[i] <= regDefault(i);
            activeBank[i] <= regDefault(i);
         end
      end
      else
      begin
         if (writeMapped)
         begin
            bufferMem[writeAddr] <= writeByte;
         end
         if (doTransfer)
         begin
            activeBank <= bufferMem;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Parallel read, synchronisers and update counter
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         readData_q <= '0;
         strobePrev_q <= 1'b0;
         refSync_q <= 2'b00;
         diffSync_q <= 2'b00;
         halfRate_q <= 1'b0;
         updateCount_q <= 32'h0;
         transferPulse_q <= 1'b0;
      end
      else
      begin
         refSync_q <= {refSync_q[0], referenceClockRunning};
         diffSync_q <= {diffSync_q[0], differentialRefclockSelect};
         strobePrev_q <= link.registerTransferStrobe;
         transferPulse_q <= doTransfer & ~link.masterReset;
         if (parRead)
         begin
            readData_q <= parReadByte;
         end
         if (link.masterReset || !intMode)
         begin
            halfRate_q <= 1'b0;
            updateCount_q <= updatePeriod;
         end
         else if (refRunning)
         begin
            halfRate_q <= ~halfRate_q;
            if (halfRate_q)
            begin
               updateCount_q <= updateCount_d;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Control outputs from the active bank, plus the synchronised select pin and the transfer pulse
   // ----------------------------------------------------------------------
   wire logic [DATA_W-1:0] powerReg = activeBank[POWER_DOWN_ADDR];
   wire logic [DATA_W-1:0] multReg = activeBank[CLK_MULT_ADDR];
   wire logic [DATA_W-1:0] bypassReg = activeBank[BYPASS_ADDR];

   // Codes outside 4 to 20 are passed through untouched; the clocking they
   // produce is unspecified.
   assign multiplierFactor = multReg[MULT_MSB:MULT_LSB];
   assign multiplierEngaged = ~multReg[PLL_BYPASS_BIT];
   assign systemClockFromMultiplier = multiplierEngaged;
   assign pllHighRange = multReg[PLL_RANGE_BIT];
   assign referenceInputDifferential = diffSync_q[1];
   assign stagePowerDownBits = {powerReg[PWR_COMPARATOR_BIT], powerReg[PWR_CTRL_DAC_BIT],
      powerReg[PWR_DAC_BIT], powerReg[PWR_DIGITAL_BIT]};
   assign fullPowerDown = &stagePowerDownBits;
   assign invSincActiveI = ~bypassReg[INV_SINC_BYPASS_BIT];
   assign quadConverterSourceSelect = activeBank[UPDATE_MODE_ADDR][QUAD_SOURCE_BIT];
   assign invSincActiveQ = invSincActiveI & ~quadConverterSourceSelect;
   assign ampMultiplierBypass = bypassReg[AMP_BYPASS_BIT];
   assign internalUpdateMode = intMode;
   assign transferPulse = transferPulse_q;

endmodule : dcp_device

// ===== dcp_host.sv
`timescale 1ns/1ps
module dcp_host
   import dcp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Host link
   dcp_link_if.host link,
   // Mode strap
   input wire logic useParallel,
   // Command port
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [ADDR_W-1:0] cmdAddr,
   input wire logic [DATA_W-1:0] cmdData,
   output logic cmdReady,
   output logic rspValid,
   output logic [DATA_W-1:0] rspData,
   // Update and reset requests
   input wire logic updateRequest,
   input wire logic resetRequest
);

   dcp_host_state_type state_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic wen_q;
   logic ren_q;
   logic sclk_q;
   logic csN_q;
   logic [SERIAL_FRAME_BITS-1:0] tx_q;
   logic [DATA_W-1:0] rx_q;
   logic readOp_q;
   logic [4:0] bitIdx_q;
   logic [3:0] count_q;
   logic [1:0] strobeCount_q;
   logic masterReset_q;
   logic rspValid_q;
   logic [DATA_W-1:0] rspData_q;

   wire logic phaseDone = (count_q == 4'h0);

   assign link.parallelSelect = useParallel;
   assign link.address = addr_q;
   assign link.writeData = wdata_q;
   assign link.writeEn = wen_q;
   assign link.readEn = ren_q;
   assign link.serialClock = sclk_q;
   assign link.serialChipSelectN = csN_q;
   assign link.serialDataIn = tx_q[SERIAL_FRAME_BITS-1];
   assign link.registerTransferStrobe = (strobeCount_q != 2'h0);
   assign link.masterReset = masterReset_q;
   assign cmdReady = (state_q == HOST_IDLE) & ~resetRequest;
   assign rspValid = rspValid_q;
   assign rspData = rspData_q;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= HOST_IDLE;
         addr_q <= '0;
         wdata_q <= '0;
         wen_q <= 1'b0;
         ren_q <= 1'b0;
         sclk_q <= 1'b0;
         csN_q <= 1'b1;
         tx_q <= '0;
         rx_q <= '0;
         readOp_q <= 1'b0;
         bitIdx_q <= 5'h00;
         count_q <= 4'h0;
         strobeCount_q <= 2'h0;
         masterReset_q <= 1'b0;
         rspValid_q <= 1'b0;
         rspData_q <= '0;
      end
      else
      begin
         wen_q <= 1'b0;
         ren_q <= 1'b0;
         rspValid_q <= 1'b0;
         if (updateRequest)
         begin
            strobeCount_q <= 2'(UPDATE_STROBE_CYCLES);
         end
         else if (strobeCount_q != 2'h0)
         begin
            strobeCount_q <= strobeCount_q - 2'h1;
         end
         case (state_q)
            HOST_IDLE:
            begin
               if (resetRequest)
               begin
                  masterReset_q <= 1'b1;
                  count_q <= 4'(MASTER_RESET_CYCLES - 1);
                  state_q <= HOST_RESET;
               end
               else if (cmdValid)
               begin
                  addr_q <= cmdAddr;
                  wdata_q <= cmdData;
                  readOp_q <= ~cmdWrite;
                  if (useParallel)
                  begin
                     wen_q <= cmdWrite;
                     ren_q <= ~cmdWrite;
                     if (!cmdWrite)
                     begin
                        state_q <= HOST_PAR_WAIT;
                     end
                  end
                  else
                  begin
                     tx_q <= {~cmdWrite, 1'b0, cmdAddr, cmdData};
                     csN_q <= 1'b0;
                     sclk_q <= 1'b0;
                     bitIdx_q <= 5'h00;
                     count_q <= 4'(SERIAL_HALF_CYCLES - 1);
                     state_q <= HOST_SERIAL;
                  end
               end
            end
            HOST_PAR_WAIT:
            begin
               // Read data lands one cycle after the read pulse, so that cycle is waited out.
               if (!ren_q)
               begin
                  rspValid_q <= 1'b1;
                  rspData_q <= link.readData;
                  state_q <= HOST_IDLE;
               end
            end
            HOST_SERIAL:
            begin
               if (!phaseDone)
               begin
                  count_q <= count_q - 4'h1;
               end
               else
               begin
                  count_q <= 4'(SERIAL_HALF_CYCLES - 1);
                  sclk_q <= ~sclk_q;
                  if (!sclk_q)
                  begin
                     rx_q <= {rx_q[DATA_W-2:0], link.serialDataOut};
                  end
                  else if (bitIdx_q == SERIAL_LAST_BIT)
                  begin
                     csN_q <= 1'b1;
                     rspValid_q <= readOp_q;
                     rspData_q <= rx_q;
                     state_q <= HOST_IDLE;
                  end
                  else
                  begin
                     tx_q <= {tx_q[SERIAL_FRAME_BITS-2:0], 1'b0};
                     bitIdx_q <= bitIdx_q + 5'h01;
                  end
               end
            end
            HOST_RESET:
            begin
               if (phaseDone)
               begin
                  masterReset_q <= 1'b0;
                  state_q <= HOST_IDLE;
               end
               else
               begin
                  count_q <= count_q - 4'h1;
               end
            end
            default:
            begin
               state_q <= HOST_IDLE;
            end
         endcase
      end
   end

endmodule : dcp_host

// ===== dcp_link_monitor.sv
`timescale 1ns/1ps
module dcp_link_monitor
   import dcp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Link signals
   input wire logic parallelSelect,
   input wire logic [DATA_W-1:0] readData,
   input wire logic writeEn,
   input wire logic readEn,
   input wire logic serialClock,
   input wire logic serialChipSelectN,
   input wire logic serialDataOut,
   input wire logic registerTransferStrobe,
   input wire logic masterReset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // Counts how long master reset has stood high.
   logic [3:0] mrLen_q;
   always_ff @(posedge clk or negedge resetn)
      if (!resetn) mrLen_q <= 4'h0;
      else mrLen_q <= masterReset ? mrLen_q + 4'h1 : 4'h0;

   mr_length_a: assert property ($fell(masterReset) |-> mrLen_q == 4'(MASTER_RESET_CYCLES))
      else $error("master reset not held ten cycles");
   mr_quiet_a: assert property (masterReset |-> serialChipSelectN && !writeEn && !readEn)
      else $error("access during master reset");
   strobe_width_a: assert property ($rose(registerTransferStrobe) |=> registerTransferStrobe
      ##1 !registerTransferStrobe)
      else $error("transfer strobe not two cycles");
   par_mode_a: assert property (writeEn || readEn |-> parallelSelect)
      else $error("parallel access in serial mode");
   ser_mode_a: assert property (!serialChipSelectN |-> !parallelSelect)
      else $error("serial frame in parallel mode");
   sclk_idle_a: assert property (serialChipSelectN |-> !serialClock)
      else $error("serial clock runs outside frame");
   sclk_half_a: assert property ($rose(serialClock) |=> serialClock ##1 !serialClock)
      else $error("serial clock high time wrong");
   sdo_quiet_a: assert property (serialChipSelectN && $past(serialChipSelectN)
      |-> !serialDataOut)
      else $error("serial output driven outside frame");
   rdata_hold_a: assert property (parallelSelect && $changed(readData) |-> $past(readEn))
      else $error("read data changed without read");
endmodule : dcp_link_monitor

// ===== dds_clock_power_config_test.sv
`timescale 1ns/1ps
module dds_clock_power_config_test
   import dcp_pkg::*;
;
   logic clk = 1'b0, resetn = 1'b0, useParallel = 1'b1, cmdValid = 1'b0, cmdWrite = 1'b0;
   logic updateRequest = 1'b0, resetRequest = 1'b0;
   logic differentialRefclockSelect = 1'b0, referenceClockRunning = 1'b1;
   logic [ADDR_W-1:0] cmdAddr = '0;
   logic [DATA_W-1:0] cmdData = '0, rspData;
   logic cmdReady, rspValid, transferPulse, multiplierEngaged, systemClockFromMultiplier;
   logic pllHighRange, referenceInputDifferential, fullPowerDown, invSincActiveI;
   logic invSincActiveQ, ampMultiplierBypass, quadConverterSourceSelect, internalUpdateMode;
   logic [MULT_MSB:MULT_LSB] multiplierFactor;
   logic [3:0] stagePowerDownBits;
   int fails = 0, n_compared = 0;
   logic [7:0] pv [5] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h17};
   wire logic [7:0] clkSt = {multiplierEngaged, systemClockFromMultiplier, pllHighRange,
      multiplierFactor};
   wire logic [7:0] pwrSt = {fullPowerDown, stagePowerDownBits, invSincActiveI,
      invSincActiveQ, ampMultiplierBypass};
   wire logic [7:0] modeSt = {5'h00, internalUpdateMode, quadConverterSourceSelect,
      referenceInputDifferential};

   always #12.5 clk = ~clk;

   dcp_link_if dcp_link_if_i ();
   dcp_device dcp_device_i (.clk, .resetn, .link(dcp_link_if_i), .differentialRefclockSelect,
      .referenceClockRunning, .multiplierFactor, .multiplierEngaged, .systemClockFromMultiplier,
      .pllHighRange, .referenceInputDifferential, .stagePowerDownBits, .fullPowerDown,
      .invSincActiveI, .invSincActiveQ, .ampMultiplierBypass, .quadConverterSourceSelect,
      .internalUpdateMode, .transferPulse);
   dcp_host dcp_host_i (.clk, .resetn, .link(dcp_link_if_i), .useParallel, .cmdValid, .cmdWrite,
      .cmdAddr, .cmdData, .cmdReady, .rspValid, .rspData, .updateRequest, .resetRequest);
   dcp_link_monitor dcp_link_monitor_i (.clk, .resetn,
      .parallelSelect(dcp_link_if_i.parallelSelect), .readData(dcp_link_if_i.readData),
      .writeEn(dcp_link_if_i.writeEn), .readEn(dcp_link_if_i.readEn),
      .serialClock(dcp_link_if_i.serialClock), .serialDataOut(dcp_link_if_i.serialDataOut),
      .serialChipSelectN(dcp_link_if_i.serialChipSelectN),
      .registerTransferStrobe(dcp_link_if_i.registerTransferStrobe),
      .masterReset(dcp_link_if_i.masterReset));

   // ----------------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------------
   task tick;
      @(posedge clk);
      #2;
   endtask : tick

   // One bounded wait step; a wait that runs out ends the run as a mismatch.
   task wt(inout int k);
      tick;
      k++;
      if (k > 500)
      begin
         fails++;
         results;
      end
   endtask : wt

   task chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d = 8'h00);
      int k = 0;
      while (cmdReady !== 1'b1) wt(k);
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdAddr = a;
      cmdData = d;
      tick;
      cmdValid = 1'b0;
      if (!w)
         while (rspValid !== 1'b1) wt(k);
      else
         tick;
   endtask : acc

   task automatic upd(output int n);
      int k = 0;
      n = 0;
      while (cmdReady !== 1'b1) wt(k);
      updateRequest = 1'b1;
      tick;
      updateRequest = 1'b0;
      repeat (12)
      begin
         tick;
         if (transferPulse === 1'b1) n++;
      end
   endtask : upd

   task done(input string s);
      $display("test %s finished", s);
   endtask : done

   task results;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   // ----------------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------------
   initial
   begin
      int i;
      int n;
      logic [7:0] v;
      repeat (4) @(posedge clk);
      #2 resetn = 1'b1;
      tick;
      chk(clkSt, 8'h04);
      chk(pwrSt, 8'h06);
      acc(1'b0, CLK_MULT_ADDR);
      chk(rspData, 8'h24);
      acc(1'b1, CLK_MULT_ADDR, 8'h54);
      repeat (4) tick;
      chk(clkSt, 8'h04);
      acc(1'b0, CLK_MULT_ADDR);
      chk(rspData, 8'h54);
      upd(n);
      chk(8'(n), 8'h01);
      chk(clkSt, 8'hf4);
      for (i = 4; i <= 20; i++)
      begin
         acc(1'b1, CLK_MULT_ADDR, 8'(i));
         upd(n);
         chk(clkSt, 8'hc0 | 8'(i));
      end
      done("multiplier");
      for (i = 0; i < 5; i++)
      begin
         v = pv[i];
         acc(1'b1, POWER_DOWN_ADDR, v);
         upd(n);
         chk(pwrSt, {&{v[4], v[2], v[1], v[0]}, v[4], v[2], v[1], v[0], 3'b110});
      end
      acc(1'b1, POWER_DOWN_ADDR, 8'h00);
      acc(1'b1, BYPASS_ADDR, 8'h60);
      acc(1'b1, UPDATE_MODE_ADDR, 8'h10);
      upd(n);
      chk(pwrSt, 8'h01);
      chk(modeSt, 8'h02);
      acc(1'b1, BYPASS_ADDR, 8'h00);
      upd(n);
      chk(pwrSt, 8'h04);
      done("power and bypass");
      referenceClockRunning = 1'b0;
      acc(1'b1, BYPASS_ADDR, 8'h40);
      acc(1'b0, BYPASS_ADDR);
      chk(rspData, 8'h40);
      upd(n);
      chk(8'(n), 8'h00);
      chk(pwrSt, 8'h04);
      referenceClockRunning = 1'b1;
      repeat (3) tick;
      upd(n);
      chk(pwrSt, 8'h00);
      done("reference clock");
      acc(1'b1, UPDATE_CLK_ADDR_0, 8'h03);
      acc(1'b1, UPDATE_MODE_ADDR, 8'h01);
      upd(n);
      chk(modeSt, 8'h04);
      n = 0;
      while (transferPulse !== 1'b1) wt(n);
      n = 0;
      do wt(n); while (transferPulse !== 1'b1);
      chk(8'(n), 8'h08);
      acc(1'b1, UPDATE_MODE_ADDR, 8'h00);
      repeat (20) tick;
      chk(modeSt, 8'h00);
      differentialRefclockSelect = 1'b1;
      repeat (3) tick;
      chk(modeSt, 8'h01);
      done("update and inputs");
      useParallel = 1'b0;
      acc(1'b1, CLK_MULT_ADDR, 8'h4a);
      chk(8'(dcp_link_if_i.parallelSelect), 8'h00);
      acc(1'b0, CLK_MULT_ADDR);
      chk(rspData, 8'h4a);
      upd(n);
      chk(clkSt, 8'hea);
      done("serial");
      useParallel = 1'b1;
      resetRequest = 1'b1;
      tick;
      resetRequest = 1'b0;
      acc(1'b0, CLK_MULT_ADDR);
      chk(rspData, 8'h24);
      chk(clkSt, 8'h04);
      chk(pwrSt, 8'h06);
      done("master reset");
      results;
   end
endmodule : dds_clock_power_config_test
